// >>> core/fps_sequencer.sv
// fps_sequencer: unlock-guarded program/erase sequencer with holding
// latches, reached over Avalon-MM.
// assumes the flash macro accepts one word write per FLASH_PROG pulse
// and one erase per FLASH_ERASE / FLASH_ERASE_ALL pulse.
//
// Notes on behaviour
// - key 55h then AAh needed before start
// - key register is write-only, reads zero
// - processor stalled while operation runs
// - trigger bit 15 starts, hardware clears
// - trigger settable only by software
// - write-enable bit 14 gates all operations
// - bit 13 flags improper attempt or termination
// - erase bit 6 picks erase or program
// - 0001 row, 0011 word, 0010 page erase
// - 1111 bulk erase, serial mode only
// - unused control bits ignore writes, read zero
// - control bits reset only at power-on
// - erase 8-row block, program 64-word row
// - single word program from write latch
// - erasing last page clears configuration words
// - target address is page plus pointer
// - table writes only fill holding latches; a high-word write also steps the pointer
`timescale 1ns/1ps
module fps_sequencer
   import fps_pkg::*;
#(
   parameter int P_WORD_CYC  = fps_pkg::WORD_CYC,
   parameter int P_ROW_CYC   = fps_pkg::ROW_CYC,
   parameter int P_BLOCK_CYC = fps_pkg::BLOCK_CYC,
   parameter int P_BULK_CYC  = fps_pkg::BULK_CYC
) (
   input  wire logic                  CLK,              // system clock
   input  wire logic                  ARST_N,           // power-on reset
   input  wire logic                  SOFT_RST_N,       // other resets
   input  wire logic                  SERIAL_PROG_MODE, // serial mode
   input  wire logic [fps_pkg::AW-1:0] AVS_ADDRESS,     // byte address
   input  wire logic                  AVS_READ,         // read request
   input  wire logic                  AVS_WRITE,        // write request
   input  wire logic [31:0]           AVS_WRITEDATA,    // write data
   input  wire logic [3:0]            AVS_BYTEENABLE,   // byte lanes
   output logic      [31:0]           AVS_READDATA,     // read data
   output logic                       AVS_WAITREQUEST,  // bus stall
   output logic                       CPU_STALL,        // op running
   output logic      [23:0]           FLASH_ADDR,       // flash address
   output logic      [23:0]           FLASH_DATA,       // word to program
   output logic                       FLASH_PROG,       // word write pulse
   output logic                       FLASH_ERASE,      // block erase pulse
   output logic                       FLASH_ERASE_ALL   // bulk erase pulse
);
   import fps_pkg::*;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                           input logic [1:0] be);
      merge16 = {be[1] ? new_v[15:8] : old_v[15:8],
                 be[0] ? new_v[7:0]  : old_v[7:0]};
   endfunction

   function automatic fps_cmd_t decode_op(input logic [3:0] op, input logic ers, input logic serial);
      decode_op = FPS_NONE;
      if (op == OP_ROW && !ers)
         decode_op = FPS_ROW;
      if (op == OP_WORD && !ers)
         decode_op = FPS_WORD;
      if (op == OP_BLOCK && ers)
         decode_op = FPS_BLOCK;
      if (op == OP_BULK && ers && serial)
         decode_op = FPS_BULK;
   endfunction

   // ------------------------------------------------------------
   // reset and input synchronisers
   // ------------------------------------------------------------
   logic rst_s1_reg;
   logic rst_n;
   logic soft_s1_reg;
   logic soft_s2_reg;
   logic mode_s1_reg;
   logic mode_s2_reg;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         soft_s1_reg <= 1'b1;
         soft_s2_reg <= 1'b1;
         mode_s1_reg <= 1'b0;
         mode_s2_reg <= 1'b0;
      end else begin
         soft_s1_reg <= SOFT_RST_N;
         soft_s2_reg <= soft_s1_reg;
         mode_s1_reg <= SERIAL_PROG_MODE;
         mode_s2_reg <= mode_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic             trig_reg;
   logic             operation_write_enable_reg;
   logic             err_reg;
   logic             erase_reg;
   logic [3:0]       op_reg;
   logic [1:0]       key_reg;
   logic [7:0]       page_reg;
   logic [15:0]      ptr_reg;
   logic             wait_reg;
   logic [31:0]      rdata_reg;
   fps_state_t       state_reg;
   fps_state_t       state_next;
   logic [IDX_W-1:0] step_reg;
   logic [TMR_W-1:0] tmr_reg;
   logic [23:0]      addr_reg;
   logic [23:0]      data_reg;
   logic             prog_reg;
   logic             ers_reg;
   logic             ersall_reg;
   logic [23:0]      latch_mem [0:63];

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire        soft_rst = ~soft_s2_reg;
   wire        req      = AVS_READ | AVS_WRITE;
   wire        grant    = req & wait_reg & ~trig_reg;
   wire        take_wr  = AVS_WRITE & ~wait_reg;
   wire        hit_ctrl = AVS_ADDRESS == OFS_CTRL;
   wire        hit_key  = AVS_ADDRESS == OFS_KEY;
   wire        hit_page = AVS_ADDRESS == OFS_PAGE;
   wire        hit_ptr  = AVS_ADDRESS == OFS_PTR;
   wire        hit_twl  = AVS_ADDRESS == OFS_TWL;
   wire        hit_twh  = AVS_ADDRESS == OFS_TWH;
   wire        hit_tad  = AVS_ADDRESS == OFS_TADDR;
   wire [15:0] wdat     = AVS_WRITEDATA[15:0];
   wire [1:0]  be_lo    = AVS_BYTEENABLE[1:0];

   wire [15:0] ctrl_img = {trig_reg, operation_write_enable_reg, err_reg, 6'h00,
                           erase_reg, 2'h0, op_reg};
   wire [15:0] ctrl_new = merge16(ctrl_img, wdat, be_lo);
   wire [23:0] target   = {page_reg, ptr_reg};
   wire [IDX_W-1:0] idx = ptr_reg[IDX_W:1];
   wire [23:0] lat_cur  = latch_mem[idx];
   wire [31:0] rd_mux   =
      hit_ctrl ? {16'h0000, ctrl_img} :
      hit_page ? {24'h000000, page_reg} :
      hit_ptr  ? {16'h0000, ptr_reg} :
      hit_twl  ? {16'h0000, lat_cur[15:0]} :
      hit_twh  ? {24'h000000, lat_cur[23:16]} :
      hit_tad  ? {8'h00, target} : 32'h0000_0000;

   // ------------------------------------------------------------
   // trigger and unlock decisions
   // ------------------------------------------------------------
   wire       wr_ctrl  = take_wr & hit_ctrl;
   wire       wr_key   = take_wr & hit_key & AVS_BYTEENABLE[0];
   wire       trig_try = wr_ctrl & ctrl_new[BIT_TRIG];
   wire       armed    = key_reg == 2'h2;
   wire       new_operation_write_enable = ctrl_new[BIT_OPERATION_WRITE_ENABLE];
   fps_cmd_t  go_cmd;
   assign go_cmd = decode_op(ctrl_new[OP_MSB:0], ctrl_new[BIT_ERASE], mode_s2_reg);
   wire       start    = trig_try & armed & new_operation_write_enable & (go_cmd != FPS_NONE);
   wire       seq_err  = trig_try & ~(armed & new_operation_write_enable);
   wire       abort    = soft_rst & trig_reg;
   wire       done     = (state_reg == FPS_WAIT) && (tmr_reg == '0);

   wire [1:0] key_next =
      (soft_rst | trig_try) ? 2'h0 :
      wr_key ? ((AVS_WRITEDATA[7:0] == KEY_FIRST) ? 2'h1 :
                (AVS_WRITEDATA[7:0] == KEY_SECOND &&
                 key_reg == 2'h1) ? 2'h2 : 2'h0) :
      take_wr ? 2'h0 : key_reg;

   wire trig_next = start ? 1'b1 :
                    (done | abort) ? 1'b0 : trig_reg;
   // set wins over software clear
   wire err_next  = (seq_err | abort) ? 1'b1 :
                    start ? 1'b0 :
                    wr_ctrl ? ctrl_new[BIT_ERR] : err_reg;

   // ------------------------------------------------------------
   // operation timing
   // ------------------------------------------------------------
   wire [TMR_W-1:0] dur =
      (go_cmd == FPS_ROW)   ? TMR_W'(P_ROW_CYC - 1) :
      (go_cmd == FPS_WORD)  ? TMR_W'(P_WORD_CYC - 1) :
      (go_cmd == FPS_BLOCK) ? TMR_W'(P_BLOCK_CYC - 1) :
                              TMR_W'(P_BULK_CYC - 1);
   wire [23:0] row_base = {target[23:ROW_ALIGN], {ROW_ALIGN{1'b0}}};
   wire [23:0] blk_base = {target[23:BLK_ALIGN], {BLK_ALIGN{1'b0}}};
   wire [23:0] row_addr = {addr_reg[23:ROW_ALIGN], step_reg, 1'b0};

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         FPS_IDLE: begin
            if (start)
               state_next = (go_cmd == FPS_ROW) ? FPS_STEP : FPS_WAIT;
         end
         FPS_STEP: begin
            if (abort)
               state_next = FPS_IDLE;
            else if (step_reg == ROW_LAST)
               state_next = FPS_WAIT;
         end
         FPS_WAIT: begin
            if (abort | done)
               state_next = FPS_IDLE;
         end
         default: state_next = FPS_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // control register, power-on reset only
   // ------------------------------------------------------------
   // only the power-on reset clears these
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         trig_reg  <= CTRL_RST[BIT_TRIG];
         operation_write_enable_reg  <= CTRL_RST[BIT_OPERATION_WRITE_ENABLE];
         err_reg   <= CTRL_RST[BIT_ERR];
         erase_reg <= CTRL_RST[BIT_ERASE];
         op_reg    <= CTRL_RST[OP_MSB:0];
      end else begin
         trig_reg  <= trig_next;
         err_reg   <= err_next;
         // erase flag stored for next trigger
         if (wr_ctrl) begin
            operation_write_enable_reg  <= new_operation_write_enable;
            erase_reg <= ctrl_new[BIT_ERASE];
            op_reg    <= ctrl_new[OP_MSB:0];
         end
      end
   end

   // ------------------------------------------------------------
   // bus slave, key and table pointer
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
         key_reg   <= 2'h0;
         page_reg  <= 8'h00;
         ptr_reg   <= 16'h0000;
      end else begin
         wait_reg <= ~grant;
         key_reg  <= key_next;
         if (grant)
            rdata_reg <= rd_mux;
         if (take_wr & hit_page & be_lo[0])
            page_reg <= wdat[7:0];
         if (take_wr & hit_ptr)
            ptr_reg <= merge16(ptr_reg, wdat, be_lo);
         else if (take_wr & hit_twh)
            ptr_reg <= ptr_reg + {8'h00, PTR_STEP};
      end
   end

   // ------------------------------------------------------------
   // holding latches
   // ------------------------------------------------------------
   // no reset: latch contents start unknown, as the flash expects
   // software to fill unused words before a row program
   wire lat_ok = ~page_reg[CFG_BIT];
   always_ff @(posedge CLK) begin
      if (take_wr & hit_twl & lat_ok)
         latch_mem[idx][15:0] <= merge16(lat_cur[15:0], wdat, be_lo);
      if (take_wr & hit_twh & lat_ok & AVS_BYTEENABLE[0])
         latch_mem[idx][23:16] <= wdat[7:0];
   end

   // ------------------------------------------------------------
   // operation engine
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= FPS_IDLE;
         step_reg   <= '0;
         tmr_reg    <= '0;
         addr_reg   <= 24'h000000;
         data_reg   <= 24'h000000;
         prog_reg   <= 1'b0;
         ers_reg    <= 1'b0;
         ersall_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         prog_reg   <= 1'b0;
         ers_reg    <= 1'b0;
         ersall_reg <= 1'b0;
         if (start) begin
            step_reg <= '0;
            tmr_reg  <= dur;
            unique case (go_cmd)
               FPS_ROW: addr_reg <= row_base;
               FPS_WORD: begin
                  addr_reg <= target;
                  data_reg <= lat_cur;
                  prog_reg <= 1'b1;
               end
               // last block takes config words too
               FPS_BLOCK: begin
                  addr_reg <= blk_base;
                  ers_reg  <= 1'b1;
               end
               FPS_BULK: ersall_reg <= 1'b1;
               default: ;
            endcase
         end else if (state_reg == FPS_STEP && !abort) begin
            addr_reg <= row_addr;
            data_reg <= latch_mem[step_reg];
            prog_reg <= 1'b1;
            step_reg <= step_reg + 1'b1;
         end else if (state_reg == FPS_WAIT && !done) begin
            tmr_reg <= tmr_reg - 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign AVS_READDATA    = rdata_reg;
   assign AVS_WAITREQUEST = wait_reg;
   assign CPU_STALL       = trig_reg;
   assign FLASH_ADDR      = addr_reg;
   assign FLASH_DATA      = data_reg;
   assign FLASH_PROG      = prog_reg;
   assign FLASH_ERASE     = ers_reg;
   assign FLASH_ERASE_ALL = ersall_reg;

endmodule // fps_sequencer

// >>> pkg/fps_pkg.sv
// fps_pkg: register map, field layout, command codes and timing for
// the flash program/erase sequencer.
// assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
package fps_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam int         AW        = 5;
   localparam logic [4:0] OFS_CTRL  = 5'h00;
   localparam logic [4:0] OFS_KEY   = 5'h04;
   localparam logic [4:0] OFS_PAGE  = 5'h08;
   localparam logic [4:0] OFS_PTR   = 5'h0C;
   localparam logic [4:0] OFS_TWL   = 5'h10;
   localparam logic [4:0] OFS_TWH   = 5'h14;
   localparam logic [4:0] OFS_TADDR = 5'h18;

   // ------------------------------------------------------------
   // flash_operation_control fields
   // ------------------------------------------------------------
   localparam int          BIT_TRIG  = 15;
   localparam int          BIT_OPERATION_WRITE_ENABLE  = 14;
   localparam int          BIT_ERR   = 13;
   localparam int          BIT_ERASE = 6;
   localparam int          OP_MSB    = 3;
   localparam int          CFG_BIT   = 7;
   localparam logic [15:0] CTRL_RST  = 16'h0000;

   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   localparam logic [3:0] OP_ROW   = 4'h1;
   localparam logic [3:0] OP_BLOCK = 4'h2;
   localparam logic [3:0] OP_WORD  = 4'h3;
   localparam logic [3:0] OP_BULK  = 4'hF;

   // ------------------------------------------------------------
   // geometry: 64-word rows, 8-row (512-word) erase blocks
   // ------------------------------------------------------------
   localparam int         IDX_W      = 6;
   localparam logic [5:0] ROW_LAST   = 6'h3F;
   localparam int         ROW_ALIGN  = 7;
   localparam int         BLK_ALIGN  = 10;
   localparam logic [7:0] PTR_STEP   = 8'h02;

   // ------------------------------------------------------------
   // self-timed durations
   // ------------------------------------------------------------
   localparam int CLK_MHZ     = 125;
   localparam int T_WORD_US   = 40;
   localparam int T_ROW_US    = 2000;
   localparam int T_BLOCK_US  = 20000;
   localparam int T_BULK_US   = 40000;
   localparam int WORD_CYC    = T_WORD_US * CLK_MHZ;
   localparam int ROW_CYC     = T_ROW_US * CLK_MHZ;
   localparam int BLOCK_CYC   = T_BLOCK_US * CLK_MHZ;
   localparam int BULK_CYC    = T_BULK_US * CLK_MHZ;
   localparam int TMR_W       = 24;

   typedef enum logic [2:0] {
      FPS_IDLE = 3'b001,
      FPS_STEP = 3'b010,
      FPS_WAIT = 3'b100
   } fps_state_t;

   typedef enum logic [2:0] {
      FPS_NONE  = 3'h0,
      FPS_ROW   = 3'h1,
      FPS_WORD  = 3'h2,
      FPS_BLOCK = 3'h3,
      FPS_BULK  = 3'h4
   } fps_cmd_t;

endpackage

// >>> bench/fps_sequencer_sva.sv
// fps_sva: port-level checks of the flash program/erase sequencer.
// assumes the bus master holds each request until waitrequest drops.
`timescale 1ns/1ps
module fps_sva
   import fps_pkg::*;
(
   input wire logic                   CLK,              // clock
   input wire logic                   ARST_N,           // power-on reset
   input wire logic                   SERIAL_PROG_MODE, // serial mode
   input wire logic [fps_pkg::AW-1:0] AVS_ADDRESS,      // byte address
   input wire logic                   AVS_READ,         // read request
   input wire logic                   AVS_WRITE,        // write request
   input wire logic [31:0]            AVS_WRITEDATA,    // write data
   input wire logic [31:0]            AVS_READDATA,     // read data
   input wire logic                   AVS_WAITREQUEST,  // bus stall
   input wire logic                   CPU_STALL,        // op running
   input wire logic [23:0]            FLASH_ADDR,       // flash address
   input wire logic                   FLASH_PROG,       // word pulse
   input wire logic                   FLASH_ERASE,      // block pulse
   input wire logic                   FLASH_ERASE_ALL   // bulk pulse
);
   // ------------------------------------------------------------
   // accepted accesses and sequences
   // ------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   wire rd_ok = AVS_READ && !AVS_WAITREQUEST;
   wire trig_acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_CTRL
                   && AVS_WRITEDATA[BIT_TRIG] && AVS_WRITEDATA[BIT_OPERATION_WRITE_ENABLE];
   wire pulse = FLASH_PROG || FLASH_ERASE || FLASH_ERASE_ALL;
   sequence s_run; CPU_STALL [*8]; endsequence
   sequence s_done; ##[1:200] !CPU_STALL; endsequence

   property p_stall_wait; CPU_STALL |-> AVS_WAITREQUEST; endproperty
   a_stall_wait: assert property (p_stall_wait) else $error("bus served during operation");
   property p_start; $rose(CPU_STALL) |-> $past(trig_acc); endproperty
   a_start: assert property (p_start) else $error("start without enabled trigger");
   property p_hold; $rose(CPU_STALL) |-> s_run; endproperty
   a_hold: assert property (p_hold) else $error("stall ended too soon");
   property p_end; $rose(CPU_STALL) |-> s_done; endproperty
   a_end: assert property (p_end) else $error("operation never finished");
   property p_key_rd; rd_ok && AVS_ADDRESS == OFS_KEY |-> AVS_READDATA == 32'h0; endproperty
   a_key_rd: assert property (p_key_rd) else $error("key register readable");
   property p_unused;
      rd_ok && AVS_ADDRESS == OFS_CTRL |-> AVS_READDATA[31:16] == 16'h0
         && AVS_READDATA[12:7] == 6'h0 && AVS_READDATA[5:4] == 2'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused control bits set");
   property p_no_direct; pulse |-> CPU_STALL; endproperty
   a_no_direct: assert property (p_no_direct) else $error("flash touched outside operation");
   property p_align; FLASH_ERASE |-> FLASH_ADDR[9:0] == 10'h0 ##1 !FLASH_ERASE; endproperty
   a_align: assert property (p_align) else $error("erase not block aligned");
   property p_bulk; FLASH_ERASE_ALL |-> $past(SERIAL_PROG_MODE, 3); endproperty
   a_bulk: assert property (p_bulk) else $error("bulk erase outside serial mode");
endmodule // fps_sva

bind fps_sequencer fps_sva fps_sva_inst (.CLK, .ARST_N, .SERIAL_PROG_MODE, .AVS_ADDRESS, .AVS_READ,
   .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .CPU_STALL, .FLASH_ADDR,
   .FLASH_PROG, .FLASH_ERASE, .FLASH_ERASE_ALL);

// >>> bench/fps_cpu_model.sv
// fps_cpu_model: processor side, an Avalon-MM master with waitrequest.
// assumes one slave; no wait has a timeout of its own, only the bench hang guard.
`timescale 1ns/1ps
module fps_cpu_model
   import fps_pkg::*;
(
   input  wire logic        clk,         // clock
   input  wire logic        waitrequest, // slave stall
   input  wire logic [31:0] readdata,    // read data
   output logic      [4:0]  address,     // byte address
   output logic             read,        // read request
   output logic             write,       // write request
   output logic      [31:0] writedata,   // write data
   output logic      [3:0]  byteenable   // byte lanes
);
   initial begin
      address = 5'h1F;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'hF;
   end
   // released lines show the inverse, never the last value
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      wr_be(a, d, 4'hF);
   endtask
   // write with chosen byte lanes, held with the request
   task automatic wr_be(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
      @(posedge clk);
      address <= a;
      writedata <= d;
      byteenable <= b;
      write <= 1'b1;
      @(posedge clk);
      while (waitrequest) @(posedge clk);
      write <= 1'b0;
      writedata <= ~d;
      byteenable <= ~b;
      address <= ~a;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      address <= a;
      read <= 1'b1;
      @(posedge clk);
      while (waitrequest) @(posedge clk);
      d = readdata;
      read <= 1'b0;
      address <= ~a;
   endtask
   task automatic unlock();
      wr(OFS_KEY, 32'h55);
      wr(OFS_KEY, 32'hAA);
   endtask
   task automatic run(input logic [15:0] c, output logic [31:0] r);
      wr(OFS_CTRL, {16'h0, c});
      unlock();
      wr(OFS_CTRL, {16'h0, c | 16'h8000});
      repeat (2) @(posedge clk);
      r = 32'h8000;
      while (r[BIT_TRIG] !== 1'b0) rd(OFS_CTRL, r);
   endtask
endmodule // fps_cpu_model

// >>> bench/fps_sequencer_tb_top.sv
// fps_sequencer_tb_top: self-checking bench of the sequencer.
// assumes the processor model drives the register bus.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module fps_sequencer_tb_top;
   import fps_pkg::*;
   // short self-timed counts keep the run brief
   localparam int WORD_N = 10;
   logic        clk = 1'b0, arst_n = 1'b0, soft_rst_n = 1'b1, serial = 1'b0;
   logic [4:0]  adr;
   logic [3:0]  be;
   logic [31:0] wd, rdat;
   logic        rq, wq, wait_r, stall, f_prog, f_ers, f_all;
   logic [23:0] f_addr, f_data, last_addr, last_data;
   int          fail_count = 0, comparisons = 0, cyc = 0, n_prog = 0, n_ers = 0, n_all = 0;
   always #4 clk = ~clk;
   fps_sequencer #(.P_WORD_CYC(WORD_N), .P_ROW_CYC(12), .P_BLOCK_CYC(14), .P_BULK_CYC(16))
   fps_sequencer_inst (.CLK(clk), .ARST_N(arst_n), .SOFT_RST_N(soft_rst_n), .SERIAL_PROG_MODE(serial),
      .AVS_ADDRESS(adr), .AVS_READ(rq), .AVS_WRITE(wq), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
      .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r), .CPU_STALL(stall), .FLASH_ADDR(f_addr),
      .FLASH_DATA(f_data), .FLASH_PROG(f_prog), .FLASH_ERASE(f_ers), .FLASH_ERASE_ALL(f_all));
   fps_cpu_model cpu (.clk(clk), .waitrequest(wait_r), .readdata(rdat), .address(adr), .read(rq),
      .write(wq), .writedata(wd), .byteenable(be));
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // pulse monitor and hang guard
   always @(posedge clk) begin
      cyc++;
      n_prog += int'(f_prog === 1'b1);
      n_ers += int'(f_ers === 1'b1);
      n_all += int'(f_all === 1'b1);
      if (f_prog || f_ers) begin
         last_addr = f_addr;
         last_data = f_data;
      end
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      logic [31:0] r;
      logic [15:0] c;
      int np, ne, na, c0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      cpu.rd(OFS_CTRL, r); `CHK(r, 32'h0)
      cpu.wr(OFS_CTRL, 32'hFFFF);
      cpu.rd(OFS_CTRL, r); `CHK(r, 32'h604F)
      `CHK(n_prog + n_ers + n_all, 0)
      cpu.wr(OFS_CTRL, 32'h0);
      cpu.rd(OFS_CTRL, r); `CHK(r, 32'h0)
      cpu.wr(OFS_KEY, 32'h55);
      cpu.rd(OFS_KEY, r); `CHK(r, 32'h0)
      cpu.wr(OFS_PTR, 32'h3404);
      cpu.wr(OFS_KEY, 32'hAA);
      cpu.wr(OFS_CTRL, 32'hC003);
      cpu.rd(OFS_CTRL, r); `CHK(r, 32'h6003)
      cpu.run(16'h0003, r); `CHK(r, 32'h2003)
      cpu.wr(OFS_PAGE, 32'h12);
      cpu.wr(OFS_TWL, 32'hBEEF);
      cpu.wr(OFS_TWH, 32'hA5);
      cpu.wr_be(OFS_PTR, 32'h12FF, 4'h2);
      cpu.rd(OFS_PTR, r); `CHK(r, 32'h1206)
      cpu.wr(OFS_PTR, 32'h3404);
      `CHK(n_prog, 0)
      c0 = cyc;
      cpu.run(16'h4003, r); `CHK(r, 32'h4003)
      `CHK(cyc - c0 > WORD_N, 1'b1)
      `CHK(n_prog, 1)
      `CHK(last_addr, 24'h123404)
      `CHK(last_data, 24'hA5BEEF)
      cpu.wr(OFS_PAGE, 32'h92);
      cpu.wr(OFS_TWL, 32'h1234);
      cpu.rd(OFS_TWL, r); `CHK(r, 32'hBEEF)
      cpu.wr(OFS_PAGE, 32'h12);
      cpu.rd(OFS_TADDR, r); `CHK(r, 32'h123404)
      cpu.wr(OFS_CTRL, 32'hC003);
      cpu.rd(OFS_CTRL, r); `CHK(r, 32'h6003)
      cpu.wr(OFS_CTRL, 32'h0);
      for (int s = 0; s < 2; s++) begin
         serial <= s[0];
         repeat (4) @(posedge clk);
         for (int k = 0; k < 32; k++) begin
            c = 16'h4000 | (16'(k[4]) << BIT_ERASE) | 16'(k[3:0]);
            np = n_prog;
            ne = n_ers;
            na = n_all;
            cpu.run(c, r); `CHK(r, {16'h0, c})
            `CHK(n_prog - np, (k == 1) ? 64 : (k == 3) ? 1 : 0)
            `CHK(n_ers - ne, int'(k == 18))
            `CHK(n_all - na, int'(k == 31 && s == 1))
            if (k == 1) `CHK(last_addr, 24'h12347E)
            if (k == 18) `CHK(last_addr, 24'h123400)
         end
      end
      // abort a block erase in mid-run by a non-power-on reset
      cpu.wr(OFS_CTRL, 32'h4042);
      cpu.unlock();
      cpu.wr(OFS_CTRL, 32'hC042);
      repeat (6) @(posedge clk);
      soft_rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      soft_rst_n <= 1'b1;
      cpu.rd(OFS_CTRL, r); `CHK(r, 32'h6042)
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      cpu.rd(OFS_CTRL, r); `CHK(r, 32'h0)
      end_of_test();
   end
endmodule // fps_sequencer_tb_top
